/* logic/pxc_pkg.sv */
package pxc_pkg;
  // five-level symbol encoding, two's complement in three bits
  localparam logic [2:0] SYM_P2 = 3'h2;
  localparam logic [2:0] SYM_P1 = 3'h1;
  localparam logic [2:0] SYM_Z  = 3'h0;
  localparam logic [2:0] SYM_M1 = 3'h7;
  localparam logic [2:0] SYM_M2 = 3'h6;

  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned SAMPLE_MS      = 62;
  localparam int unsigned A_TIMER_MS     = 1300;
  localparam int unsigned MAXWAIT_M_MS   = 750;
  localparam int unsigned MAXWAIT_S_MS   = 350;
  localparam int unsigned MINWAIT_US     = 1;
  localparam int unsigned STABILIZE_US   = 1;
  localparam int unsigned SAMPLE_CYC     = SAMPLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned A_TIMER_CYC    = A_TIMER_MS * 1000 * CLK_MHZ;
  localparam int unsigned MAXWAIT_M_CYC  = MAXWAIT_M_MS * 1000 * CLK_MHZ;
  localparam int unsigned MAXWAIT_S_CYC  = MAXWAIT_S_MS * 1000 * CLK_MHZ;
  localparam int unsigned MINWAIT_CYC    = MINWAIT_US * CLK_MHZ;
  localparam int unsigned STABILIZE_CYC  = STABILIZE_US * CLK_MHZ;

  localparam logic [10:0] LFSR_SEED_RST  = 11'h5A3;

  // apb register offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_SEED    = 12'h008;
  localparam logic [11:0] REG_TXSYM   = 12'h00C;
  localparam logic [11:0] REG_RXSYM   = 12'h010;

  // control field positions
  localparam int unsigned CTRL_LINK_EN  = 0;
  localparam int unsigned CTRL_MASTER   = 1;
  localparam int unsigned CTRL_XOVER_EN = 2;
  localparam int unsigned CTRL_PMA_RST  = 3;
  localparam logic [31:0] CTRL_RST      = 32'h00000004;

  typedef enum logic [2:0] {
    PHY_DISABLE  = 3'h0,
    PHY_SILENT   = 3'h1,
    PHY_TRAINING = 3'h2,
    PHY_IDLE     = 3'h3,
    PHY_DATA     = 3'h4
  } pxc_phy_e;

  typedef enum logic [1:0] {
    LM_FAIL  = 2'h0,
    LM_HOLD  = 2'h1,
    LM_UP    = 2'h2
  } pxc_lm_e;

  typedef enum logic [1:0] {
    TXM_N = 2'h0,
    TXM_I = 2'h1,
    TXM_Z = 2'h2
  } pxc_txm_e;

  typedef struct packed {
    logic [2:0] a;
    logic [2:0] b;
    logic [2:0] c;
    logic [2:0] d;
  } pxc_sym_s;

  typedef struct packed {
    logic loc_ok;
    logic rem_ok;
    logic scr_ok;
    logic link_pulse;
    logic tx_pulse;
  } pxc_rx_s;
endpackage : pxc_pkg

/* logic/pxc_timer.sv */
`timescale 1ns/10ps
module pxc_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] limit,
  output logic              running,
  output logic              done
);
  logic [W-1:0] count;

  initial begin
    if (W < 2) $error("pxc_timer width too small");
  end

  // stop clears and halts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (stop) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (start) begin
      count   <= '0;
      running <= 1'b1;
      done    <= 1'b0;
    end else if (running) begin
      if (count >= limit - W'(1)) begin
        running <= 1'b0;
        done    <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end
endmodule : pxc_timer

/* logic/pxc_lfsr.sv */
`timescale 1ns/10ps
module pxc_lfsr (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [10:0] seed,
  input  wire logic        step,
  output logic             swap_decision_bit
);
  logic [10:0] s;

  // x^11 + x^9 + 1, maximal length; all-zero seed replaced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= pxc_pkg::LFSR_SEED_RST;
    end else if (load) begin
      s <= (seed == 11'h000) ? pxc_pkg::LFSR_SEED_RST : seed;
    end else if (step) begin
      s <= {s[9:0], s[10] ^ s[8]};
    end
  end

  assign swap_decision_bit = s[10];
endmodule : pxc_lfsr

/* logic/pxc_phy_ctrl.sv */
`timescale 1ns/10ps
// Contract
// - send one five-level symbol per pair
// - capture one received symbol per pair
// - optional swap A/B, C/D before negotiation
// - 11-bit shift register drives proposal
// - advance once per sample, decide bit 10
// - keep wiring when link seen
// - no link: step, maybe switch wiring
// - pulse in progress freezes crossover
// - link-detected since sample timer start
// - sample window 62 ms
// - free 1.3 s timer restarts crossover
// - stopping a timer clears it
// - maxwait 750 ms master, 350 slave
// - maxwait expiry with receiver bad fails
// - minwait 1 us bounds control states
// - receiver ok 1 us before link up
// - three transmit modes normal idle zero
// - role driven out continuously
// - local receiver status from rx path
// - remote receiver status from rx coding
// - wiring state reports straight or crossed
// - attachment reset; pulse flag only sending
// - silent with zeros, master trains at once
// - after minwait pick data or idle
module pxc_phy_ctrl #(
  parameter int unsigned SAMPLE_CYC    = pxc_pkg::SAMPLE_CYC,
  parameter int unsigned A_TIMER_CYC   = pxc_pkg::A_TIMER_CYC,
  parameter int unsigned MAXWAIT_M_CYC = pxc_pkg::MAXWAIT_M_CYC,
  parameter int unsigned MAXWAIT_S_CYC = pxc_pkg::MAXWAIT_S_CYC,
  parameter int unsigned MINWAIT_CYC   = pxc_pkg::MINWAIT_CYC,
  parameter int unsigned STAB_CYC      = pxc_pkg::STABILIZE_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire pxc_pkg::pxc_sym_s tx_sym,
  input  wire pxc_pkg::pxc_sym_s rx_pair,
  input  wire pxc_pkg::pxc_rx_s  rx_stat,
  output pxc_pkg::pxc_sym_s      tx_pair,
  output pxc_pkg::pxc_sym_s      rx_sym,
  output logic                   swap_pairs,
  output logic                   wiring_state,
  output logic                   is_master,
  output logic [1:0]             tx_mode,
  output logic                   link_ok,
  output logic                   loc_rcvr_ok,
  output logic                   rem_rcvr_ok,
  output logic                   pulse_active,
  output logic                   pma_reset
);
  localparam int unsigned TW = 32;

  initial begin
    if (MINWAIT_CYC < 2 || STAB_CYC < 2 || SAMPLE_CYC < 2) $error("pxc_phy_ctrl timer too short");
    if (A_TIMER_CYC <= SAMPLE_CYC) $error("pxc_phy_ctrl free timer must exceed sample window");
  end

  // status inputs come from other logic: two-stage synchroniser
  pxc_pkg::pxc_rx_s st_meta;
  pxc_pkg::pxc_rx_s st;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_meta <= '0;
      st      <= '0;
    end else begin
      st_meta <= rx_stat;
      st      <= st_meta;
    end
  end

  // apb registers
  logic [31:0] ctrl;
  logic [10:0] seed;
  logic        seed_load;
  logic        apb_wr;
  logic        apb_rd;
  assign apb_wr  = psel && penable && pwrite;
  // read data loaded in setup so it stands through the access phase
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == pxc_pkg::REG_CTRL) || (a == pxc_pkg::REG_STATUS) || (a == pxc_pkg::REG_SEED)
           || (a == pxc_pkg::REG_TXSYM) || (a == pxc_pkg::REG_RXSYM);
  endfunction : addr_ok

  assign pslverr = psel && penable && !addr_ok(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= pxc_pkg::CTRL_RST;
      seed      <= pxc_pkg::LFSR_SEED_RST;
      seed_load <= 1'b0;
    end else begin
      seed_load <= 1'b0;
      if (apb_wr && paddr == pxc_pkg::REG_CTRL) begin
        ctrl <= {28'h0000000, pwdata[3:0]};
      end else if (apb_wr && paddr == pxc_pkg::REG_SEED) begin
        seed      <= pwdata[10:0];
        seed_load <= 1'b1;
      end
    end
  end

  logic link_en;
  logic xover_en;
  assign link_en   = ctrl[pxc_pkg::CTRL_LINK_EN];
  assign is_master = ctrl[pxc_pkg::CTRL_MASTER];
  assign xover_en  = ctrl[pxc_pkg::CTRL_XOVER_EN];
  assign pma_reset = ctrl[pxc_pkg::CTRL_PMA_RST];

  pxc_pkg::pxc_phy_e phy;
  pxc_pkg::pxc_lm_e  lm;
  logic [1:0]        xs;
  logic              link_det;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      if (paddr == pxc_pkg::REG_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == pxc_pkg::REG_STATUS) begin
        prdata <= {20'h00000, link_det, xs, lm, phy, wiring_state, pulse_active, rem_rcvr_ok, loc_rcvr_ok};
      end else if (paddr == pxc_pkg::REG_SEED) begin
        prdata <= {21'h000000, seed};
      end else if (paddr == pxc_pkg::REG_TXSYM) begin
        prdata <= {20'h00000, tx_pair};
      end else if (paddr == pxc_pkg::REG_RXSYM) begin
        prdata <= {20'h00000, rx_sym};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  assign loc_rcvr_ok  = st.loc_ok;
  assign rem_rcvr_ok  = st.rem_ok;
  assign pulse_active = st.tx_pulse;

  // timers
  logic mx_start, mx_stop, mx_done;
  logic mn_start, mn_stop, mn_done;
  logic sb_start, sb_stop, sb_done;
  logic sp_start, sp_done;
  logic at_done, at_run;
  logic [TW-1:0] mx_limit;
  assign mx_limit = is_master ? TW'(MAXWAIT_M_CYC) : TW'(MAXWAIT_S_CYC);

  pxc_timer #(.W(TW)) u_maxwait (
    .pclk(pclk), .presetn(presetn), .start(mx_start), .stop(mx_stop),
    .limit(mx_limit), .running(), .done(mx_done));
  pxc_timer #(.W(TW)) u_minwait (
    .pclk(pclk), .presetn(presetn), .start(mn_start), .stop(mn_stop),
    .limit(TW'(MINWAIT_CYC)), .running(), .done(mn_done));
  pxc_timer #(.W(TW)) u_stab (
    .pclk(pclk), .presetn(presetn), .start(sb_start), .stop(sb_stop),
    .limit(TW'(STAB_CYC)), .running(), .done(sb_done));
  pxc_timer #(.W(TW)) u_sample (
    .pclk(pclk), .presetn(presetn), .start(sp_start), .stop(pma_reset),
    .limit(TW'(SAMPLE_CYC)), .running(), .done(sp_done));
  pxc_timer #(.W(TW)) u_atimer (
    .pclk(pclk), .presetn(presetn), .start(!at_run), .stop(1'b0),
    .limit(TW'(A_TIMER_CYC)), .running(at_run), .done(at_done));

  pxc_pkg::pxc_phy_e next_phy;
  always_comb begin
    next_phy = phy;
    case (phy)
      pxc_pkg::PHY_DISABLE:  if (link_en) next_phy = pxc_pkg::PHY_SILENT;
      pxc_pkg::PHY_SILENT:   if (is_master || st.scr_ok) next_phy = pxc_pkg::PHY_TRAINING;
      pxc_pkg::PHY_TRAINING: if (mn_done && st.loc_ok) begin
        next_phy = st.rem_ok ? pxc_pkg::PHY_DATA : pxc_pkg::PHY_IDLE;
      end
      pxc_pkg::PHY_IDLE: begin
        if (mn_done && !st.loc_ok) next_phy = pxc_pkg::PHY_SILENT;
        else if (mn_done && st.rem_ok) next_phy = pxc_pkg::PHY_DATA;
      end
      pxc_pkg::PHY_DATA: begin
        if (mn_done && !st.loc_ok) next_phy = pxc_pkg::PHY_SILENT;
        else if (mn_done && !st.rem_ok) next_phy = pxc_pkg::PHY_IDLE;
      end
      default: next_phy = pxc_pkg::PHY_DISABLE;
    endcase
    if (!link_en || pma_reset) next_phy = pxc_pkg::PHY_DISABLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phy <= pxc_pkg::PHY_DISABLE;
    else          phy <= next_phy;
  end

  logic phy_enter;
  assign phy_enter = next_phy != phy;
  assign mx_start = phy_enter && next_phy == pxc_pkg::PHY_SILENT;
  assign mx_stop  = pma_reset || (phy_enter && (next_phy == pxc_pkg::PHY_IDLE || next_phy == pxc_pkg::PHY_DATA
                    || next_phy == pxc_pkg::PHY_DISABLE));
  assign mn_start = phy_enter && (next_phy == pxc_pkg::PHY_TRAINING || next_phy == pxc_pkg::PHY_IDLE
                    || next_phy == pxc_pkg::PHY_DATA);
  assign mn_stop  = pma_reset || (phy_enter && (next_phy == pxc_pkg::PHY_SILENT || next_phy == pxc_pkg::PHY_DISABLE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mode <= pxc_pkg::TXM_Z;
    end else if (next_phy == pxc_pkg::PHY_DATA) begin
      tx_mode <= pxc_pkg::TXM_N;
    end else if (next_phy == pxc_pkg::PHY_TRAINING || next_phy == pxc_pkg::PHY_IDLE) begin
      tx_mode <= pxc_pkg::TXM_I;
    end else begin
      tx_mode <= pxc_pkg::TXM_Z;
    end
  end

  // link monitor
  pxc_pkg::pxc_lm_e next_lm;
  always_comb begin
    next_lm = lm;
    case (lm)
      pxc_pkg::LM_FAIL: if (st.loc_ok && link_en) next_lm = pxc_pkg::LM_HOLD;
      pxc_pkg::LM_HOLD: begin
        if (!st.loc_ok) next_lm = pxc_pkg::LM_FAIL;
        else if (sb_done) next_lm = pxc_pkg::LM_UP;
      end
      pxc_pkg::LM_UP: if (!st.loc_ok) next_lm = pxc_pkg::LM_FAIL;
      default: next_lm = pxc_pkg::LM_FAIL;
    endcase
    if ((mx_done && !st.loc_ok) || !link_en || pma_reset) next_lm = pxc_pkg::LM_FAIL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lm <= pxc_pkg::LM_FAIL;
    else          lm <= next_lm;
  end

  assign sb_start = next_lm == pxc_pkg::LM_HOLD && lm != pxc_pkg::LM_HOLD;
  assign sb_stop  = next_lm == pxc_pkg::LM_FAIL && lm != pxc_pkg::LM_FAIL;
  assign link_ok  = lm == pxc_pkg::LM_UP;

  // crossover machine: 0 init, 1 sampling, 2 locked
  logic       swap_bit;
  logic       lf_step;
  logic [1:0] next_xs;
  pxc_lfsr u_lfsr (
    .pclk(pclk), .presetn(presetn), .load(seed_load), .seed(seed),
    .step(lf_step), .swap_decision_bit(swap_bit));

  always_comb begin
    next_xs = xs;
    lf_step = 1'b0;
    case (xs)
      2'h0: next_xs = 2'h1;
      2'h1: if (sp_done) begin
        if (link_det) next_xs = 2'h2;
        else lf_step = 1'b1;
        if (!link_det) next_xs = 2'h0;
      end
      2'h2: if (!link_det && sp_done) next_xs = 2'h0;
      default: next_xs = 2'h0;
    endcase
    if (at_done && xs != 2'h2) next_xs = 2'h0;
    if (st.tx_pulse) begin
      next_xs = xs;
      lf_step = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) xs <= 2'h0;
    else if (pma_reset || !xover_en || lm == pxc_pkg::LM_UP) xs <= 2'h0;
    else xs <= next_xs;
  end

  // decision from bit 10 after step
  logic swap_next;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) swap_next <= 1'b0;
    else if (pma_reset || !xover_en) swap_next <= 1'b0;
    else if (xs == 2'h0 && next_xs == 2'h1 && !st.tx_pulse && lm != pxc_pkg::LM_UP && swap_bit) swap_next <= !swap_next;
  end
  // swap only when enabled, before negotiation; reported
  assign swap_pairs   = swap_next;
  assign wiring_state = swap_next;

  assign sp_start = !pma_reset && xs == 2'h0 && next_xs == 2'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_det <= 1'b0;
    else if (sp_start) link_det <= st.link_pulse || lm == pxc_pkg::LM_UP;
    else if (st.link_pulse || lm == pxc_pkg::LM_UP) link_det <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pair <= '0;
      rx_sym  <= '0;
    end else if (pma_reset) begin
      tx_pair <= '0;
      rx_sym  <= '0;
    end else begin
      tx_pair.a <= tx_mode == pxc_pkg::TXM_Z ? pxc_pkg::SYM_Z : (swap_pairs ? tx_sym.b : tx_sym.a);
      tx_pair.b <= tx_mode == pxc_pkg::TXM_Z ? pxc_pkg::SYM_Z : (swap_pairs ? tx_sym.a : tx_sym.b);
      tx_pair.c <= tx_mode == pxc_pkg::TXM_Z ? pxc_pkg::SYM_Z : (swap_pairs ? tx_sym.d : tx_sym.c);
      tx_pair.d <= tx_mode == pxc_pkg::TXM_Z ? pxc_pkg::SYM_Z : (swap_pairs ? tx_sym.c : tx_sym.d);
      rx_sym.a  <= swap_pairs ? rx_pair.b : rx_pair.a;
      rx_sym.b  <= swap_pairs ? rx_pair.a : rx_pair.b;
      rx_sym.c  <= swap_pairs ? rx_pair.d : rx_pair.c;
      rx_sym.d  <= swap_pairs ? rx_pair.c : rx_pair.d;
    end
  end
endmodule : pxc_phy_ctrl

/* verification/pxc_phy_ctrl_properties.sv */
`timescale 1ns/10ps
module pxc_phy_ctrl_props #(
  parameter int unsigned STAB_CYC = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire pxc_pkg::pxc_sym_s tx_sym,
  input wire pxc_pkg::pxc_sym_s rx_pair,
  input wire pxc_pkg::pxc_rx_s  rx_stat,
  input wire pxc_pkg::pxc_sym_s tx_pair,
  input wire pxc_pkg::pxc_sym_s rx_sym,
  input wire logic              swap_pairs,
  input wire logic              wiring_state,
  input wire logic              is_master,
  input wire logic [1:0]        tx_mode,
  input wire logic              link_ok,
  input wire logic              loc_rcvr_ok,
  input wire logic              rem_rcvr_ok,
  input wire logic              pulse_active,
  input wire logic              pma_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic pxc_pkg::pxc_sym_s xo(input pxc_pkg::pxc_sym_s s, input logic x);
    return x ? {s.b, s.a, s.d, s.c} : s;
  endfunction : xo

  // run length of good local receiver, saturating so it never wraps to zero
  logic [7:0] ok_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ok_run <= 8'h00;
    else if (!loc_rcvr_ok)
      ok_run <= 8'h00;
    else if (ok_run != 8'hFF)
      ok_run <= ok_run + 8'h01;
  end

  sequence s_tx_live;
    $past(presetn) && tx_mode != pxc_pkg::TXM_Z && $past(tx_mode) != pxc_pkg::TXM_Z;
  endsequence
  sequence s_rx_live;
    $past(presetn) && !$past(pma_reset) && $stable(swap_pairs);
  endsequence

  property p_tx_map;
    s_tx_live ##0 $stable(swap_pairs) |-> tx_pair == xo($past(tx_sym), swap_pairs);
  endproperty
  property p_tx_zero;
    tx_mode == pxc_pkg::TXM_Z && $past(tx_mode) == pxc_pkg::TXM_Z |-> tx_pair == '0;
  endproperty
  property p_rx_map;
    s_rx_live |-> rx_sym == xo($past(rx_pair), swap_pairs);
  endproperty
  property p_wiring;
    wiring_state == swap_pairs;
  endproperty
  property p_loc;
    $past(presetn) && $past(presetn, 2) |-> loc_rcvr_ok == $past(rx_stat.loc_ok, 2);
  endproperty
  property p_rem;
    $past(presetn) && $past(presetn, 2) |-> rem_rcvr_ok == $past(rx_stat.rem_ok, 2);
  endproperty
  property p_pulse;
    $past(presetn) && $past(presetn, 2) |-> pulse_active == $past(rx_stat.tx_pulse, 2);
  endproperty
  property p_freeze;
    pulse_active |=> $stable(swap_pairs);
  endproperty
  property p_stab;
    $rose(link_ok) |-> ok_run >= STAB_CYC - 1;
  endproperty
  property p_fail;
    !loc_rcvr_ok [*3] |-> !link_ok;
  endproperty

  a_tx_map: assert property (p_tx_map) else $error("tx pair mapping wrong");
  a_tx_zero: assert property (p_tx_zero) else $error("zero mode not silent");
  a_rx_map: assert property (p_rx_map) else $error("rx pair mapping wrong");
  a_wiring: assert property (p_wiring) else $error("wiring state mismatch");
  a_loc: assert property (p_loc) else $error("local receiver status wrong");
  a_rem: assert property (p_rem) else $error("remote receiver status wrong");
  a_pulse: assert property (p_pulse) else $error("pulse flag wrong");
  a_freeze: assert property (p_freeze) else $error("wiring moved during pulse");
  a_stab: assert property (p_stab) else $error("link up too early");
  a_fail: assert property (p_fail) else $error("link kept with bad receiver");
endmodule : pxc_phy_ctrl_props

bind pxc_phy_ctrl pxc_phy_ctrl_props #(.STAB_CYC(STAB_CYC)) u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .tx_sym, .rx_pair, .rx_stat, .tx_pair, .rx_sym,
  .swap_pairs, .wiring_state, .is_master, .tx_mode, .link_ok, .loc_rcvr_ok, .rem_rcvr_ok, .pulse_active,
  .pma_reset);

/* verification/pxc_link_partner.sv */
`timescale 1ns/10ps
module pxc_link_partner (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire pxc_pkg::pxc_rx_s want,
  input wire logic             crossed,
  output pxc_pkg::pxc_sym_s    rx_pair,
  output pxc_pkg::pxc_rx_s     rx_stat
);
  localparam logic [2:0] LV [0:4] = '{pxc_pkg::SYM_P2, pxc_pkg::SYM_P1, pxc_pkg::SYM_Z,
                                      pxc_pkg::SYM_M1, pxc_pkg::SYM_M2};
  logic [2:0] idx;

  // pattern differs between A and B and between C and D so a crossed cable is visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx     <= 3'h0;
      rx_pair <= '0;
      rx_stat <= '0;
    end else begin
      idx     <= (idx == 3'h4) ? 3'h0 : idx + 3'h1;
      rx_pair <= crossed ? {LV[3'h4 - idx], LV[idx], LV[idx], LV[3'h4 - idx]}
                         : {LV[idx], LV[3'h4 - idx], LV[3'h4 - idx], LV[idx]};
      rx_stat <= want;
    end
  end
endmodule : pxc_link_partner

/* verification/pam5_phy_link_control_xover_test.sv */
`timescale 1ns/10ps
module pam5_phy_link_control_xover_test;
  localparam logic [2:0] LV [0:4] = '{pxc_pkg::SYM_P2, pxc_pkg::SYM_P1, pxc_pkg::SYM_Z,
                                      pxc_pkg::SYM_M1, pxc_pkg::SYM_M2};
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr, err, crossed;
  logic              swap_pairs, wiring_state, is_master, link_ok, pma_reset;
  logic              loc_rcvr_ok, rem_rcvr_ok, pulse_active;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [1:0]        tx_mode;
  pxc_pkg::pxc_sym_s tx_sym, rx_pair, tx_pair, rx_sym, exp_rx;
  pxc_pkg::pxc_rx_s  rx_stat, want;
  int                n_fail = 0;
  int                compares = 0;
  int                cycles = 0;
  int                tog, i;

  always #2.5 pclk = ~pclk;

  pxc_phy_ctrl #(.SAMPLE_CYC(50), .A_TIMER_CYC(400), .MAXWAIT_M_CYC(200), .MAXWAIT_S_CYC(100),
    .MINWAIT_CYC(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .tx_sym, .rx_pair, .rx_stat, .tx_pair, .rx_sym, .swap_pairs, .wiring_state,
    .is_master, .tx_mode, .link_ok, .loc_rcvr_ok, .rem_rcvr_ok, .pulse_active, .pma_reset);
  pxc_link_partner u_partner (.pclk, .presetn, .want, .crossed, .rx_pair, .rx_stat);

  task summarize;
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // ceiling well above the longest expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // read data and error are taken at the edge where pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a write is visible when the task returns
    @(posedge pclk);
  endtask : apb

  task wait_mode(input logic [1:0] m);
    for (i = 0; i < 400 && tx_mode !== m; i++) @(posedge pclk);
    check("tx_mode", 32'(tx_mode), 32'(m));
  endtask : wait_mode

  task watch(input int n);
    logic w;
    tog = 0;
    w = wiring_state;
    repeat (n) begin
      @(posedge pclk);
      if (wiring_state !== w) tog++;
      w = wiring_state;
    end
  endtask : watch

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    tx_sym = '0; want = '0; crossed = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pxc_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", rd, pxc_pkg::CTRL_RST);
    check("tx_mode reset", 32'(tx_mode), 32'(pxc_pkg::TXM_Z));
    check("role reset", 32'(is_master), 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h0000000C);
    check("attach reset", 32'(pma_reset), 32'h1);
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000004);
    check("attach reset off", 32'(pma_reset), 32'h0);
    watch(1000);
    check("hunting", 32'(tog != 0), 32'h1);
    want.link_pulse <= 1'b1;
    repeat (110) @(posedge pclk);
    watch(150);
    check("kept with pulses", 32'(tog), 32'h0);
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000000);
    want <= '{tx_pulse: 1'b1, default: 1'b0};
    repeat (4) @(posedge pclk);
    // crossover re-enabled at init while a pulse is being sent
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000004);
    watch(300);
    check("frozen in pulse", 32'(tog), 32'h0);
    want <= '{loc_ok: 1'b1, rem_ok: 1'b1, scr_ok: 1'b1, default: 1'b0};
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000003);
    check("role master", 32'(is_master), 32'h1);
    wait_mode(pxc_pkg::TXM_N);
    check("straight", 32'(wiring_state), 32'h0);
    for (i = 0; i < 300 && link_ok !== 1'b1; i++) @(posedge pclk);
    check("link up", 32'(link_ok), 32'h1);
    for (int k = 0; k < 5; k++) begin
      tx_sym  <= '{LV[k], LV[4-k], LV[4-k], LV[k]};
      crossed <= k[0];
      repeat (2) @(posedge pclk);
      exp_rx = rx_pair;
      @(posedge pclk);
      check("rx_sym", 32'(rx_sym), 32'(exp_rx));
      check("tx_pair", 32'(tx_pair), 32'(tx_sym));
    end
    want.rem_ok <= 1'b0;
    wait_mode(pxc_pkg::TXM_I);
    want.rem_ok <= 1'b1;
    wait_mode(pxc_pkg::TXM_N);
    want.loc_ok <= 1'b0;
    for (i = 0; i < 50 && link_ok !== 1'b0; i++) @(posedge pclk);
    check("link failed", 32'(link_ok), 32'h0);
    wait_mode(pxc_pkg::TXM_Z);
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000000);
    want <= '{loc_ok: 1'b1, rem_ok: 1'b1, default: 1'b0};
    apb(1'b1, pxc_pkg::REG_CTRL, 32'h00000001);
    repeat (30) @(posedge pclk);
    check("slave silent", 32'(tx_mode), 32'(pxc_pkg::TXM_Z));
    want.scr_ok <= 1'b1;
    wait_mode(pxc_pkg::TXM_N);
    summarize();
  end
endmodule : pam5_phy_link_control_xover_test
